// ==== phpm_pin_mux.sv ====
// Pin mux for port 1 bits 0-4, capture inputs 0-3 and scheduled outputs 0, 1, 4, 5
// Behaviour
// - Port 1 bits quasi-bidirectional via data register
// - Bit 3 pin selects modulator 1 output
// - Modulator duty per register, rate selectable
// - Bit 4 pin selects modulator 2 output
// - Capture 0 rising edge interrupts unless masked
// - Enable bit makes capture 0 feed FIFO
// - Two bits enable timer 2 reset edge
// - Enable bit makes capture 1 feed FIFO
// - Timer 2 clocked from pin when selected
// - Enable bit drives scheduled output 4
// - Capture 2 shares pin, feeds FIFO
// - Enable bit drives scheduled output 5
// - Capture 3 shares pin, feeds FIFO
// - Shared pin drives and captures own edges
// - Scheduled outputs 0, 1 always driven
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "phpm_defines.svh"

module phpm_pin_mux (
    // Clock and reset
    input  wire logic                     CLK,
    input  wire logic                     RST_N,
    // Wishbone slave
    input  wire logic                     WB_CYC_I,
    input  wire logic                     WB_STB_I,
    input  wire logic                     WB_WE_I,
    input  wire logic [7:0]               WB_ADR_I,
    input  wire logic [3:0]               WB_SEL_I,
    input  wire logic [31:0]              WB_DAT_I,
    output logic      [31:0]              WB_DAT_O,
    output logic                          WB_ACK_O,
    // Port 1 pins 0-4
    input  wire logic [4:0]               PORT_ONE_I,
    output phpm_pkg::phpm_port_drive_t    PORT_ONE_DRV,
    // Capture-only pins (capture_in_0, capture_in_1)
    input  wire logic [1:0]               CAPTURE_PIN_I,
    // Shared pins: bit 0 = sched_out_4 / capture_in_2, bit 1 = sched_out_5 / capture_in_3
    input  wire logic [1:0]               SHARED_PIN_I,
    output logic      [1:0]               SHARED_PIN_O,
    output logic      [1:0]               SHARED_PIN_OE,
    // Dedicated scheduled output pins 0 and 1
    output logic      [1:0]               SCHED_PIN_O,
    // Scheduled output unit levels: {sched_out_5, sched_out_4, sched_out_1, sched_out_0}
    input  wire logic [3:0]               SCHED_OUT,
    // Capture input unit
    output logic      [3:0]               CAPTURE_EVENT,
    output logic      [3:0]               CAPTURE_LEVEL,
    // Timer 2 controls
    output phpm_pkg::phpm_timer2_t        TIMER_TWO,
    // Interrupt to controller
    output logic                          CAPTURE0_IRQ
);

    phpm_pkg::phpm_ioc_t ioc;
    logic [7:0]          port1_data;
    logic [7:0]          duty_setting_1;
    logic [7:0]          duty_setting_2;
    logic                irq_mask;
    logic [8:0]          sync1;
    logic [8:0]          sync2;
    logic [8:0]          prev;
    logic [3:0]          cap_lvl;
    logic [3:0]          cap_prev;
    logic [3:0]          cap_en;
    logic                pwm_1;
    logic                pwm_2;
    logic [4:0]          alt_sel;
    logic                wb_req;
    logic                wb_wr;
    logic [5:0]          idx;
    logic [7:0]          next_rdata;

    // ==========================================================================
    // Helpers
    function automatic logic rising(input logic cur, input logic old);
        rising = cur & ~old;
    endfunction

    function automatic logic changed(input logic cur, input logic old);
        changed = cur ^ old;
    endfunction

    // ==========================================================================
    // Pin synchronisers: sync1 feeds only sync2
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1 <= 9'h000;
            sync2 <= 9'h000;
            prev  <= 9'h000;
        end else begin
            sync1 <= {SHARED_PIN_I, CAPTURE_PIN_I, PORT_ONE_I};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // Shared pins are sampled from the pad, so driven edges come back as events
    assign cap_lvl  = sync2[8:5];
    assign cap_prev = prev[8:5];

    // ==========================================================================
    // Wishbone slave, one wait state; write lands on the edge the master sees ack
    assign wb_req = WB_CYC_I & WB_STB_I;
    assign idx    = WB_ADR_I[7:2];
    assign wb_wr  = wb_req & WB_ACK_O & WB_WE_I & WB_SEL_I[0];

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= wb_req & ~WB_ACK_O;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        unique case (idx)
            `PHPM_IDX_PORT1_DATA: next_rdata = {port1_data[7:5], sync2[4:0]};
            `PHPM_IDX_IO_CONTROL_0:       next_rdata = ioc.io_control_0;
            `PHPM_IDX_IO_CONTROL_1:       next_rdata = ioc.io_control_1;
            `PHPM_IDX_IO_CONTROL_2:       next_rdata = ioc.io_control_2;
            `PHPM_IDX_IO_CONTROL_3:       next_rdata = ioc.io_control_3;
            `PHPM_IDX_DUTY1:      next_rdata = duty_setting_1;
            `PHPM_IDX_DUTY2:      next_rdata = duty_setting_2;
            `PHPM_IDX_IRQ_MASK:   next_rdata = {7'h00, irq_mask};
            `PHPM_IDX_PIN_STATUS: next_rdata = {2'h0, sync2[6:5], cap_lvl[3:2], sync2[4:3]};
            default:              next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (wb_req & ~WB_ACK_O) begin
            WB_DAT_O <= {24'h00_0000, next_rdata};
        end
    end

    // ==========================================================================
    // Register writes
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            port1_data <= `PHPM_PORT1_RESET;
        end else if (wb_wr && idx == `PHPM_IDX_PORT1_DATA) begin
            port1_data <= WB_DAT_I[7:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ioc <= {4{`PHPM_IOC_RESET}};
        end else if (wb_wr) begin
            if (idx == `PHPM_IDX_IO_CONTROL_0) begin
                ioc.io_control_0 <= WB_DAT_I[7:0];
            end
            if (idx == `PHPM_IDX_IO_CONTROL_1) begin
                ioc.io_control_1 <= WB_DAT_I[7:0];
            end
            if (idx == `PHPM_IDX_IO_CONTROL_2) begin
                ioc.io_control_2 <= WB_DAT_I[7:0];
            end
            if (idx == `PHPM_IDX_IO_CONTROL_3) begin
                ioc.io_control_3 <= WB_DAT_I[7:0];
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            duty_setting_1 <= `PHPM_DUTY_RESET;
            duty_setting_2 <= `PHPM_DUTY_RESET;
            irq_mask       <= `PHPM_MASK_RESET;
        end else if (wb_wr) begin
            if (idx == `PHPM_IDX_DUTY1) begin
                duty_setting_1 <= WB_DAT_I[7:0];
            end
            if (idx == `PHPM_IDX_DUTY2) begin
                duty_setting_2 <= WB_DAT_I[7:0];
            end
            if (idx == `PHPM_IDX_IRQ_MASK) begin
                irq_mask <= WB_DAT_I[0];
            end
        end
    end

    // ==========================================================================
    // Modulator
    phpm_pwm u_pwm (
        .clk    (CLK),
        .rst_n  (RST_N),
        .fast   (ioc.io_control_2[`PHPM_IO_CONTROL_2_PWM_FAST]),
        .duty_1 (duty_setting_1),
        .duty_2 (duty_setting_2),
        .pwm_1  (pwm_1),
        .pwm_2  (pwm_2)
    );

    // ==========================================================================
    // Port 1 pin drive: quasi mode pulls low on a zero, alternate mode pushes both ways
    assign alt_sel = {ioc.io_control_3[`PHPM_IO_CONTROL_3_MODULATOR_OUT_2_SEL], ioc.io_control_3[`PHPM_IO_CONTROL_3_MODULATOR_OUT_1_SEL], 3'h0};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PORT_ONE_DRV <= '0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                PORT_ONE_DRV.out[i] <= 1'b0;
                PORT_ONE_DRV.oe[i]  <= ~port1_data[i];
            end
            if (alt_sel[3]) begin
                PORT_ONE_DRV.out[3] <= pwm_1;
                PORT_ONE_DRV.oe[3]  <= 1'b1;
            end
            if (alt_sel[4]) begin
                PORT_ONE_DRV.out[4] <= pwm_2;
                PORT_ONE_DRV.oe[4]  <= 1'b1;
            end
        end
    end

    // ==========================================================================
    // Scheduled output pins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SCHED_PIN_O   <= 2'h0;
            SHARED_PIN_O  <= 2'h0;
            SHARED_PIN_OE <= 2'h0;
        end else begin
            SCHED_PIN_O   <= SCHED_OUT[1:0];
            SHARED_PIN_O  <= SCHED_OUT[3:2];
            SHARED_PIN_OE <= {ioc.io_control_1[`PHPM_IO_CONTROL_1_SCHED5_EN], ioc.io_control_1[`PHPM_IO_CONTROL_1_SCHED4_EN]};
        end
    end

    // ==========================================================================
    // Capture events toward the capture FIFO
    assign cap_en = {ioc.io_control_0[`PHPM_IO_CONTROL_0_CAP3_EN], ioc.io_control_0[`PHPM_IO_CONTROL_0_CAP2_EN],
                     ioc.io_control_0[`PHPM_IO_CONTROL_0_CAP1_EN], ioc.io_control_0[`PHPM_IO_CONTROL_0_CAP0_EN]};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CAPTURE_EVENT <= 4'h0;
            CAPTURE_LEVEL <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                CAPTURE_EVENT[i] <= cap_en[i] & changed(cap_lvl[i], cap_prev[i]);
            end
            CAPTURE_LEVEL <= cap_lvl;
        end
    end

    // ==========================================================================
    // Interrupt and timer 2 controls
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            CAPTURE0_IRQ <= 1'b0;
        end else begin
            CAPTURE0_IRQ <= rising(cap_lvl[0], cap_prev[0]) & ~irq_mask;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TIMER_TWO <= '0;
        end else begin
            TIMER_TWO.reset <= ioc.io_control_0[`PHPM_IO_CONTROL_0_TIMER_TWO_RESET_IN_A] & ioc.io_control_0[`PHPM_IO_CONTROL_0_TIMER_TWO_RESET_IN_B]
                               & rising(cap_lvl[0], cap_prev[0]);
            TIMER_TWO.clock_ext <= ioc.io_control_0[`PHPM_IO_CONTROL_0_TIMER_TWO_CLOCK_IN_EN] & ~ioc.io_control_3[`PHPM_IO_CONTROL_3_TIMER_TWO_CLOCK_IN_INT];
            TIMER_TWO.clock_evt <= ioc.io_control_0[`PHPM_IO_CONTROL_0_TIMER_TWO_CLOCK_IN_EN] & ~ioc.io_control_3[`PHPM_IO_CONTROL_3_TIMER_TWO_CLOCK_IN_INT]
                                   & rising(cap_lvl[1], cap_prev[1]);
        end
    end

    // ==========================================================================
    // Assertions
    a_irq_on_edge: assert property (@(posedge CLK) disable iff (!RST_N)
        (sync2[5] && !prev[5] && !irq_mask) |=> CAPTURE0_IRQ) else $error("edge on capture 0 gave no interrupt");
    a_irq_masked: assert property (@(posedge CLK) disable iff (!RST_N)
        CAPTURE0_IRQ |-> $past(!irq_mask) && $past(sync2[5]) && !$past(prev[5])) else $error("interrupt while masked");
    a_port_quasi: assert property (@(posedge CLK) disable iff (!RST_N)
        (!ioc.io_control_3[2] && !port1_data[3]) |=> PORT_ONE_DRV.oe[3] && !PORT_ONE_DRV.out[3]) else $error("port bit not low");
    a_modulator_out_1_pin: assert property (@(posedge CLK) disable iff (!RST_N)
        ioc.io_control_3[2] |=> PORT_ONE_DRV.oe[3] && PORT_ONE_DRV.out[3] == $past(pwm_1)) else $error("pin 3 not modulator");
    a_modulator_out_2_pin: assert property (@(posedge CLK) disable iff (!RST_N)
        ioc.io_control_3[3] |=> PORT_ONE_DRV.oe[4] && PORT_ONE_DRV.out[4] == $past(pwm_2))
        else $error("pin 4 not modulator");
    a_t2_reset: assert property (@(posedge CLK) disable iff (!RST_N)
        TIMER_TWO.reset |-> $past(ioc.io_control_0[3] && ioc.io_control_0[5]) && $past(sync2[5])) else $error("timer 2 reset unbidden");
    a_t2_clock: assert property (@(posedge CLK) disable iff (!RST_N)
        (ioc.io_control_0[7] && ioc.io_control_3[0]) |=> !TIMER_TWO.clock_evt && !TIMER_TWO.clock_ext) else $error("timer 2 clock leak");
    a_cap_enable: assert property (@(posedge CLK) disable iff (!RST_N)
        CAPTURE_EVENT[1] |-> $past(ioc.io_control_0[2]) && ($past(sync2[6]) != $past(prev[6]))) else $error("capture 1 event");
    a_sched_dedic: assert property (@(posedge CLK) disable iff (!RST_N)
        ##1 SCHED_PIN_O == $past(SCHED_OUT[1:0])) else $error("dedicated output not following");
    a_sched4_oe: assert property (@(posedge CLK) disable iff (!RST_N)
        ioc.io_control_1[4] |=> SHARED_PIN_OE[0] && SHARED_PIN_O[0] == $past(SCHED_OUT[2])) else $error("output 4 not driven");
    a_sched5_oe: assert property (@(posedge CLK) disable iff (!RST_N)
        ioc.io_control_1[6] |=> SHARED_PIN_OE[1] && SHARED_PIN_O[1] == $past(SCHED_OUT[3])) else $error("output 5 not driven");
    a_cap0_enable: assert property (@(posedge CLK) disable iff (!RST_N)
        CAPTURE_EVENT[0] |-> $past(ioc.io_control_0[0]) && ($past(sync2[5]) != $past(prev[5]))) else $error("capture 0 event");
    a_wb_ack_once: assert property (@(posedge CLK) disable iff (!RST_N)
        WB_ACK_O |=> !WB_ACK_O) else $error("ack held two cycles");

endmodule // phpm_pin_mux

// ==== phpm_defines.svh ====
// Register indices, field positions and reset values of the port 1 / capture / scheduled-output pin mux
`ifndef PHPM_DEFINES_SVH
`define PHPM_DEFINES_SVH

// ==========================================================================
// Register indices (byte address = index * 4)
`define PHPM_IDX_PORT1_DATA 6'h0f
`define PHPM_IDX_IO_CONTROL_0       6'h10
`define PHPM_IDX_IO_CONTROL_1       6'h11
`define PHPM_IDX_IO_CONTROL_2       6'h12
`define PHPM_IDX_IO_CONTROL_3       6'h13
`define PHPM_IDX_DUTY1      6'h14
`define PHPM_IDX_DUTY2      6'h15
`define PHPM_IDX_IRQ_MASK   6'h16
`define PHPM_IDX_PIN_STATUS 6'h17

// ==========================================================================
// Reset values
`define PHPM_PORT1_RESET    8'hff
`define PHPM_IOC_RESET      8'h00
`define PHPM_DUTY_RESET     8'h00
`define PHPM_MASK_RESET     1'h1

// ==========================================================================
// Field positions of io_control_0
`define PHPM_IO_CONTROL_0_CAP0_EN   0
`define PHPM_IO_CONTROL_0_CAP1_EN   2
`define PHPM_IO_CONTROL_0_TIMER_TWO_RESET_IN_A   3
`define PHPM_IO_CONTROL_0_CAP2_EN   4
`define PHPM_IO_CONTROL_0_TIMER_TWO_RESET_IN_B   5
`define PHPM_IO_CONTROL_0_CAP3_EN   6
`define PHPM_IO_CONTROL_0_TIMER_TWO_CLOCK_IN_EN  7
// Field positions of io_control_1
`define PHPM_IO_CONTROL_1_SCHED4_EN 4
`define PHPM_IO_CONTROL_1_SCHED5_EN 6
// Field positions of io_control_2
`define PHPM_IO_CONTROL_2_PWM_FAST  2
// Field positions of io_control_3
`define PHPM_IO_CONTROL_3_TIMER_TWO_CLOCK_IN_INT 0
`define PHPM_IO_CONTROL_3_MODULATOR_OUT_1_SEL  2
`define PHPM_IO_CONTROL_3_MODULATOR_OUT_2_SEL  3

// ==========================================================================
// Timing: slow modulator rate divides the core clock by this count
`define PHPM_PWM_SLOW_DIV   8'h02

`endif

// ==== phpm_pkg.sv ====
// Types shared by the pin mux files
package phpm_pkg;

    // Drive of the five port 1 pins
    typedef struct packed {
        logic [4:0] out;
        logic [4:0] oe;
    } phpm_port_drive_t;

    // Timer 2 controls taken from the capture pins
    typedef struct packed {
        logic reset;
        logic clock_evt;
        logic clock_ext;
    } phpm_timer2_t;

    // Software control bytes
    typedef struct packed {
        logic [7:0] io_control_0;
        logic [7:0] io_control_1;
        logic [7:0] io_control_2;
        logic [7:0] io_control_3;
    } phpm_ioc_t;

endpackage

// ==== phpm_pwm.sv ====
// Two-channel pulse-width modulator sharing one period counter
`timescale 1ns/1ps
`include "phpm_defines.svh"

module phpm_pwm (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Control
    input  wire logic       fast,
    input  wire logic [7:0] duty_1,
    input  wire logic [7:0] duty_2,
    // Waveforms
    output logic            pwm_1,
    output logic            pwm_2
);

    logic [7:0] div;
    logic [7:0] cnt;
    logic       tick;

    // ==========================================================================
    // Rate select
    assign tick = fast | (div == `PHPM_PWM_SLOW_DIV - 8'h01);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= 8'h00;
        end else if (tick) begin
            div <= 8'h00;
        end else begin
            div <= div + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
        end else if (tick) begin
            cnt <= cnt + 8'h01;
        end
    end

    // ==========================================================================
    // Duty compare
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_1 <= 1'b0;
            pwm_2 <= 1'b0;
        end else begin
            pwm_1 <= cnt < duty_1;
            pwm_2 <= cnt < duty_2;
        end
    end

    a_pwm_zero_duty: assert property (@(posedge clk) disable iff (!rst_n)
        duty_1 == 8'h00 |=> !pwm_1) else $error("modulator 1 high at zero duty");
    a_pwm_full_duty: assert property (@(posedge clk) disable iff (!rst_n)
        (duty_2 == 8'hff && cnt != 8'hff) |=> pwm_2) else $error("modulator 2 low below duty");

endmodule // phpm_pwm

// ==== phpm_board.sv ====
// Board model: pull-ups on port 1, event sources and the shared-pad loopback
`timescale 1ns/1ps

module phpm_board (
    // Design drive
    input  wire logic [4:0] drv_out,
    input  wire logic [4:0] drv_oe,
    input  wire logic [1:0] sh_o,
    input  wire logic [1:0] sh_oe,
    // Board stimulus
    input  wire logic [4:0] ext_low,
    input  wire logic [1:0] cap_src,
    input  wire logic [1:0] sh_src,
    // Pad levels
    output logic      [4:0] port_pad,
    output logic      [1:0] cap_pad,
    output logic      [1:0] sh_pad
);
    // ==========================================================================
    // Pads
    // Released quasi pins float high on the pull-up unless a load pulls them low
    assign port_pad = (drv_oe & drv_out) | (~drv_oe & ~ext_low);
    assign cap_pad  = cap_src;
    // A driven shared pad shows the design's own level to its capture input
    assign sh_pad   = (sh_oe & sh_o) | (~sh_oe & sh_src);
endmodule // phpm_board

// ==== phpm_pin_mux_tb.sv ====
// Self-checking bench for the port 1 / capture / scheduled-output pin mux
`timescale 1ns/1ps
`include "phpm_defines.svh"

module phpm_pin_mux_tb;
    logic                       clk = 1'b0;
    logic                       rst_n = 1'b0;
    logic                       cyc = 1'b0;
    logic                       stb = 1'b0;
    logic                       we = 1'b0;
    logic [7:0]                 adr = 8'h00;
    logic [3:0]                 sel = 4'h0;
    logic [31:0]                wdat = 32'h0;
    logic [31:0]                rdat;
    logic                       ack;
    logic [4:0]                 pin_in;
    phpm_pkg::phpm_port_drive_t drv;
    logic [1:0]                 cap_pad, sh_pad, sh_o, sh_oe, sched_pin;
    logic [3:0]                 sched = 4'h0;
    logic [3:0]                 cev, clev;
    phpm_pkg::phpm_timer2_t     t2;
    logic                       irq;
    logic [4:0]                 ext_low = 5'h00;
    logic [1:0]                 cap_src = 2'h0;
    logic [1:0]                 sh_src = 2'h0;
    int                         n_mismatch = 0;
    int                         compares = 0;
    int                         cycles = 0;
    int                         n_ev [4] = '{default: 0};
    int                         n_irq = 0;
    int                         n_rst = 0;
    int                         n_clk = 0;

    always #20 clk = ~clk;

    phpm_pin_mux phpm_pin_mux_inst (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .PORT_ONE_I(pin_in),
        .PORT_ONE_DRV(drv), .CAPTURE_PIN_I(cap_pad), .SHARED_PIN_I(sh_pad), .SHARED_PIN_O(sh_o),
        .SHARED_PIN_OE(sh_oe), .SCHED_PIN_O(sched_pin), .SCHED_OUT(sched), .CAPTURE_EVENT(cev),
        .CAPTURE_LEVEL(clev), .TIMER_TWO(t2), .CAPTURE0_IRQ(irq));

    phpm_board phpm_board_inst (.drv_out(drv.out), .drv_oe(drv.oe), .sh_o(sh_o), .sh_oe(sh_oe),
        .ext_low(ext_low), .cap_src(cap_src), .sh_src(sh_src), .port_pad(pin_in), .cap_pad(cap_pad),
        .sh_pad(sh_pad));

    // ==========================================================================
    // Pulse counters and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        for (int i = 0; i < 4; i++) begin
            if (cev[i] === 1'b1) n_ev[i] <= n_ev[i] + 1;
        end
        if (irq === 1'b1) n_irq <= n_irq + 1;
        if (t2.reset === 1'b1) n_rst <= n_rst + 1;
        if (t2.clock_evt === 1'b1) n_clk <= n_clk + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    // ==========================================================================
    // Shared tasks
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wb(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] s,
                      output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        check({31'h0, ack}, 32'h1);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, 4'hf, q);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
        logic [7:0] q;
        wb(1'b0, idx, 8'h00, 4'hf, q);
        check({24'h0, q}, {24'h0, e});
    endtask

    // Lines 0-1 come from the capture pads, lines 2-3 from the released shared pads
    task automatic pulse(input int line);
        @(posedge clk);
        if (line < 2) cap_src[line] <= 1'b1;
        else sh_src[line - 2] <= 1'b1;
        repeat (4) @(posedge clk);
        cap_src <= 2'h0;
        sh_src <= 2'h0;
        repeat (8) @(posedge clk);
    endtask

    task automatic pulse_chk(input int line, input int e_ev, input int e_irq);
        int ev0, irq0;
        ev0 = n_ev[line];
        irq0 = n_irq;
        pulse(line);
        check(n_ev[line] - ev0, e_ev);
        check(n_irq - irq0, e_irq);
    endtask

    task automatic pwm_count(input int len, input int e1, input int e2);
        int h1, h2, bad;
        h1 = 0;
        h2 = 0;
        bad = 0;
        repeat (len) begin
            settle(1);
            if (drv.out[3] === 1'b1) h1++;
            if (drv.out[4] === 1'b1) h2++;
            if (drv.oe !== 5'h1f) bad++;
        end
        check(h1, e1);
        check(h2, e2);
        check(bad, 0);
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_regs;
        // Pin synchronisers need two edges after reset before the pads read back
        settle(3);
        rd_chk(`PHPM_IDX_PORT1_DATA, 8'hff);
        rd_chk(`PHPM_IDX_IRQ_MASK, 8'h01);
        rd_chk(6'h3f, 8'h00);
        check({27'h0, drv.oe}, 32'h0);
        $display("test regs done");
    endtask

    task automatic t_port;
        logic [7:0] q;
        wr(`PHPM_IDX_PORT1_DATA, 8'he5);
        settle(1);
        check({27'h0, drv.oe}, 32'h1a);
        check({27'h0, drv.out & drv.oe}, 32'h0);
        settle(3);
        rd_chk(`PHPM_IDX_PORT1_DATA, 8'he5);
        @(posedge clk);
        ext_low <= 5'h01;
        settle(3);
        rd_chk(`PHPM_IDX_PORT1_DATA, 8'he4);
        ext_low <= 5'h00;
        // Low byte lane not selected, so the write is dropped
        wb(1'b1, `PHPM_IDX_PORT1_DATA, 8'h00, 4'he, q);
        settle(3);
        rd_chk(`PHPM_IDX_PORT1_DATA, 8'he5);
        $display("test port done");
    endtask

    task automatic t_pwm;
        wr(`PHPM_IDX_PORT1_DATA, 8'h00);
        wr(`PHPM_IDX_DUTY1, 8'h40);
        wr(`PHPM_IDX_DUTY2, 8'hc0);
        wr(`PHPM_IDX_IO_CONTROL_2, 8'h04);
        wr(`PHPM_IDX_IO_CONTROL_3, 8'h0c);
        settle(520);
        pwm_count(256, 64, 192);
        wr(`PHPM_IDX_IO_CONTROL_2, 8'h00);
        settle(520);
        pwm_count(512, 128, 384);
        wr(`PHPM_IDX_DUTY1, 8'h00);
        wr(`PHPM_IDX_DUTY2, 8'hff);
        settle(4);
        pwm_count(512, 0, 510);
        wr(`PHPM_IDX_IO_CONTROL_3, 8'h00);
        settle(2);
        check(drv, {5'h00, 5'h1f});
        wr(`PHPM_IDX_PORT1_DATA, 8'hff);
        $display("test modulator done");
    endtask

    task automatic t_capture;
        wr(`PHPM_IDX_IRQ_MASK, 8'h00);
        pulse_chk(0, 0, 1);
        wr(`PHPM_IDX_IO_CONTROL_0, 8'h55);
        pulse_chk(0, 2, 1);
        pulse_chk(1, 2, 0);
        pulse_chk(2, 2, 0);
        pulse_chk(3, 2, 0);
        wr(`PHPM_IDX_IRQ_MASK, 8'h01);
        pulse_chk(0, 2, 0);
        $display("test capture done");
    endtask

    task automatic t_timer;
        int r0, c0;
        r0 = n_rst;
        c0 = n_clk;
        wr(`PHPM_IDX_IO_CONTROL_0, 8'h08);
        pulse(0);
        pulse(1);
        check(n_rst - r0, 0);
        check(n_clk - c0, 0);
        wr(`PHPM_IDX_IO_CONTROL_0, 8'ha8);
        pulse(0);
        pulse(1);
        check(n_rst - r0, 1);
        check(n_clk - c0, 1);
        check({31'h0, t2.clock_ext}, 32'h1);
        wr(`PHPM_IDX_IO_CONTROL_3, 8'h01);
        pulse(1);
        check(n_clk - c0, 1);
        check({31'h0, t2.clock_ext}, 32'h0);
        $display("test timer done");
    endtask

    task automatic t_shared;
        int e2, e3;
        wr(`PHPM_IDX_IO_CONTROL_0, 8'h50);
        @(posedge clk);
        sched <= 4'h3;
        settle(2);
        check({30'h0, sched_pin}, 32'h3);
        check({30'h0, sh_oe}, 32'h0);
        wr(`PHPM_IDX_IO_CONTROL_1, 8'h50);
        settle(2);
        check({30'h0, sh_oe}, 32'h3);
        e2 = n_ev[2];
        e3 = n_ev[3];
        @(posedge clk);
        sched <= 4'hc;
        settle(2);
        check({28'h0, sh_o, sched_pin}, 32'hc);
        settle(8);
        check(n_ev[2] - e2, 1);
        check(n_ev[3] - e3, 1);
        check({28'h0, clev}, 32'hc);
        rd_chk(`PHPM_IDX_PIN_STATUS, 8'h0f);
        $display("test shared done");
    endtask

    // ==========================================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_port();
        t_pwm();
        t_capture();
        t_timer();
        t_shared();
        finish_test();
    end
endmodule // phpm_pin_mux_tb
